// *** hw/dmca_regs.sv ***
// Purpose: mode control register bank with a stepped two-channel attenuator
// Assumes: control words arrive parsed on clk; word_clock comes from the pin
// Notes: serial framing lives elsewhere; word_clock only paces the ramp
//
// Function
// - select bit zero writes, one reads back
// - independent half-dB attenuator per channel
// - gain is half dB times code minus 255
// - attenuation registers reset to all ones
// - shared load gate blocks new codes
// - three-bit format field, reset 101
// - two-bit de-emphasis rate field, reset 00
// - stream mode reuses rate field for filter
// - one de-emphasis enable for both channels
// - one soft mute bit for both channels
// - soft mute ramps down in up to 255 steps
// - step interval of 1,2,4,8 word clocks
// - phase invert bit flips both outputs
// - output disable forces bipolar zero
module dmca_regs #(
    parameter int CHANNELS = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ctl_valid,
    input wire logic [15:0] ctl_word,
    output logic rd_valid,
    output logic [7:0] rd_data,
    input wire logic word_clock,
    input wire logic stream_mode,
    output logic [7:0] left_level,
    output logic [7:0] right_level,
    output logic signed [8:0] left_gain_half_db,
    output logic signed [8:0] right_gain_half_db,
    output logic left_full_mute,
    output logic right_full_mute,
    output logic [2:0] audio_format_sel,
    output logic [1:0] deemph_rate_sel,
    output logic [1:0] fir_perf_sel,
    output logic deemph_enable,
    output logic phase_invert,
    output logic output_disable,
    output logic bipolar_zero,
    output logic ramp_busy
);

    // decoded control word
    wire logic is_read = ctl_word[dmca_pkg::RW_BIT];
    wire logic [6:0] addr = ctl_word[dmca_pkg::ADDR_MSB:dmca_pkg::ADDR_LSB];
    wire logic [7:0] wdata = ctl_word[dmca_pkg::DATA_MSB:0];
    wire logic wr_req = ctl_valid && !is_read;
    wire logic rd_req = ctl_valid && is_read;

    // address decode
    wire logic hit_left = (addr == dmca_pkg::LEFT_ATTEN_OFS);
    wire logic hit_right = (addr == dmca_pkg::RIGHT_ATTEN_OFS);
    wire logic hit_fmt = (addr == dmca_pkg::FMT_CTRL_OFS);
    wire logic hit_out = (addr == dmca_pkg::OUT_CTRL_OFS);

    // stored register contents
    logic [7:0] code_r [CHANNELS];      // channel_atten_code as written
    logic load_gate_r;                  // atten_load_gate
    logic [2:0] fmt_r;                  // audio_format_sel
    logic [1:0] deemph_rate_r;          // deemph_rate_sel
    logic deemph_en_r;                  // deemph_enable
    logic soft_mute_r;                  // soft mute request
    logic phase_inv_r;                  // phase_invert
    logic [1:0] step_rate_r;            // atten_step_rate
    logic out_dis_r;                    // output_disable

    // per-channel write strobes, left is channel 0
    wire logic [CHANNELS-1:0] code_wr = {wr_req && hit_right, wr_req && hit_left};

    // control register writes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            load_gate_r <= dmca_pkg::BIT_RST;
            fmt_r <= dmca_pkg::FMT_RST;
            deemph_rate_r <= dmca_pkg::DEEMPH_RATE_RST;
            deemph_en_r <= dmca_pkg::BIT_RST;
            soft_mute_r <= dmca_pkg::BIT_RST;
        end else if (wr_req && hit_fmt) begin
            load_gate_r <= wdata[dmca_pkg::LOAD_GATE_BIT];
            fmt_r <= wdata[dmca_pkg::FMT_MSB:dmca_pkg::FMT_LSB];
            deemph_rate_r <= wdata[dmca_pkg::DEEMPH_RATE_MSB:dmca_pkg::DEEMPH_RATE_LSB];
            deemph_en_r <= wdata[dmca_pkg::DEEMPH_EN_BIT];
            soft_mute_r <= wdata[dmca_pkg::SOFT_MUTE_BIT];
        end
    end

    // output register writes; low four bits belong to functions not held here
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_inv_r <= dmca_pkg::BIT_RST;
            step_rate_r <= dmca_pkg::STEP_RATE_RST;
            out_dis_r <= dmca_pkg::BIT_RST;
        end else if (wr_req && hit_out) begin
            phase_inv_r <= wdata[dmca_pkg::PHASE_INV_BIT];
            step_rate_r <= wdata[dmca_pkg::STEP_RATE_MSB:dmca_pkg::STEP_RATE_LSB];
            out_dis_r <= wdata[dmca_pkg::OUT_DIS_BIT];
        end
    end

    // readback mux; unmapped addresses and unheld bits answer zero
    wire logic [7:0] fmt_word = {load_gate_r, fmt_r, deemph_rate_r, deemph_en_r, soft_mute_r};
    wire logic [7:0] out_word = {phase_inv_r, step_rate_r, out_dis_r, 4'h0};
    wire logic [7:0] rd_mux = hit_left ? code_r[0] :
                              hit_right ? code_r[1] :
                              hit_fmt ? fmt_word :
                              hit_out ? out_word : 8'h00;

    // readback answer, one cycle after the request
    // data stays put between reads so a slow host may pick it up late
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_valid <= 1'b0;
            rd_data <= 8'h00;
        end else begin
            rd_valid <= rd_req;
            if (rd_req) begin
                rd_data <= rd_mux;
            end
        end
    end

    // word clock comes from a pin: two flops before anything looks at it
    logic wclk_meta_r;
    logic wclk_sync_r;
    logic wclk_prev_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wclk_meta_r <= 1'b0;
            wclk_sync_r <= 1'b0;
            wclk_prev_r <= 1'b0;
        end else begin
            wclk_meta_r <= word_clock;
            wclk_sync_r <= wclk_meta_r;
            wclk_prev_r <= wclk_sync_r;
        end
    end
    wire logic wclk_rise = wclk_sync_r && !wclk_prev_r;

    // interval divider: counts word clock periods, free running
    // free running keeps the logic small; the cost is that the first
    // step after a rate change may come up to one interval early
    logic [2:0] div_cnt_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt_r <= 3'h0;
        end else if (wclk_rise) begin
            div_cnt_r <= div_cnt_r + 3'h1;
        end
    end

    // mask picks 1, 2, 4 or 8 periods per step
    logic [2:0] rate_mask;
    always_comb begin
        case (dmca_pkg::dmca_rate_t'(step_rate_r))
            dmca_pkg::RATE_EVERY: rate_mask = 3'h0;
            dmca_pkg::RATE_HALF: rate_mask = 3'h1;
            dmca_pkg::RATE_QUARTER: rate_mask = 3'h3;
            default: rate_mask = 3'h7;
        endcase
    end
    wire logic step_tick = wclk_rise && ((div_cnt_r & rate_mask) == 3'h0);

    // check helper: word clock rises seen since the last step tick
    // a rate write restarts the count, since the free divider may then
    // give one short first interval that the rules allow
    logic [3:0] rise_gap_r;             // rises since last tick, saturating
    logic gap_valid_r;                  // a tick at a stable rate has been seen
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rise_gap_r <= 4'h0;
            gap_valid_r <= 1'b0;
        end else if (wr_req && hit_out) begin
            // rate may change here: forget the old spacing
            rise_gap_r <= 4'h0;
            gap_valid_r <= 1'b0;
        end else if (step_tick) begin
            // a tick closes one interval and opens the next
            rise_gap_r <= 4'h0;
            gap_valid_r <= 1'b1;
        end else if (wclk_rise && rise_gap_r != 4'hf) begin
            // count the periods between ticks, stop at the top
            rise_gap_r <= rise_gap_r + 4'h1;
        end
    end

    // per-channel target and applied level
    logic [7:0] target_r [CHANNELS];    // code accepted through the gate
    logic [7:0] level_r [CHANNELS];     // level actually applied
    logic [CHANNELS-1:0] moving;

    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
            // soft mute overrides the target but keeps it for release
            wire logic [7:0] goal = soft_mute_r ? dmca_pkg::SOFT_MUTE_CODE : target_r[ch];

            // written code always readable back
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    code_r[ch] <= dmca_pkg::ATTEN_RST;
                end else if (code_wr[ch]) begin
                    code_r[ch] <= wdata;
                end
            end

            // gate closed: applied target keeps its old value
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    target_r[ch] <= dmca_pkg::ATTEN_RST;
                end else if (code_wr[ch] && load_gate_r) begin
                    target_r[ch] <= wdata;
                end
            end

            // one half-dB step per tick, never a jump, avoids zipper clicks
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    level_r[ch] <= dmca_pkg::ATTEN_RST;
                end else if (step_tick && level_r[ch] < goal) begin
                    level_r[ch] <= level_r[ch] + 8'h01;
                end else if (step_tick && level_r[ch] > goal) begin
                    level_r[ch] <= level_r[ch] - 8'h01;
                end
            end

            assign moving[ch] = (level_r[ch] != goal);
        end
    endgenerate

    // applied levels and their meaning in half-dB units
    assign left_level = level_r[0];
    assign right_level = level_r[1];
    assign left_gain_half_db = $signed({1'b0, level_r[0]}) - $signed(dmca_pkg::UNITY_CODE);
    assign right_gain_half_db = $signed({1'b0, level_r[1]}) - $signed(dmca_pkg::UNITY_CODE);
    assign left_full_mute = (level_r[0] <= dmca_pkg::MUTE_MAX_CODE);
    assign right_full_mute = (level_r[1] <= dmca_pkg::MUTE_MAX_CODE);
    assign ramp_busy = |moving;

    // mode outputs straight from their registers, except the rate field, which stream mode steers
    assign audio_format_sel = fmt_r;
    // stream mode hands the same field to the analog fir instead
    assign deemph_rate_sel = stream_mode ? 2'h0 : deemph_rate_r;
    assign fir_perf_sel = stream_mode ? deemph_rate_r : 2'h0;
    assign deemph_enable = deemph_en_r;
    assign phase_invert = phase_inv_r;
    assign output_disable = out_dis_r;
    // bipolar zero wins over any incoming audio
    assign bipolar_zero = out_dis_r;

    // checks
    // all of them live in the clk domain; the word clock is only seen
    // through its synchroniser, so no check needs a second clock
    // reset disables them, the async clear leaves no history to compare
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_read_answer: assert property (rd_req |=> rd_valid && rd_data == $past(rd_mux))
        else $error("readback missing or wrong");
    chk_write_no_answer: assert property (!rd_req |=> !rd_valid)
        else $error("answer without a read request");
    chk_gate_blocks: assert property (code_wr[0] && !load_gate_r |=> target_r[0] == $past(target_r[0]))
        else $error("closed gate let a code through");
    chk_gate_loads: assert property (code_wr[1] && load_gate_r |=> target_r[1] == $past(wdata))
        else $error("open gate did not load the code");
    chk_level_one_step: assert property (level_r[0] != $past(level_r[0]) |->
        (level_r[0] - $past(level_r[0]) == 8'h01) || ($past(level_r[0]) - level_r[0] == 8'h01))
        else $error("attenuator jumped more than one step");
    chk_step_on_tick: assert property (!step_tick |=> $stable(level_r[1]))
        else $error("level moved without a step tick");
    // at the eighth rate seven untouched rises lie between two ticks
    chk_rate_spacing: assert property (step_tick && step_rate_r == 2'h3 && gap_valid_r |->
        rise_gap_r == 4'h7)
        else $error("eighth rate stepped at the wrong period");
    chk_mute_ramp_down: assert property (soft_mute_r && step_tick && level_r[0] != 8'h00 |=>
        level_r[0] == $past(level_r[0]) - 8'h01)
        else $error("soft mute did not step down");
    chk_mute_decode: assert property (left_full_mute == (left_level < 8'h0f))
        else $error("full mute flag wrong");
    chk_zero_forced: assert property (wr_req && hit_out && wdata[dmca_pkg::OUT_DIS_BIT] |=> bipolar_zero)
        else $error("output disable did not force bipolar zero");
    chk_stream_swap: assert property (stream_mode |-> deemph_rate_sel == 2'h0 && fir_perf_sel == deemph_rate_r)
        else $error("stream mode did not move the rate field");

    // mode fields follow their writes on the very next cycle
    chk_format_follows: assert property (wr_req && hit_fmt |=>
        audio_format_sel == $past(wdata[dmca_pkg::FMT_MSB:dmca_pkg::FMT_LSB]))
        else $error("format field did not take the write");
    chk_deemph_follows: assert property (wr_req && hit_fmt |=>
        deemph_enable == $past(wdata[dmca_pkg::DEEMPH_EN_BIT]))
        else $error("de-emphasis enable did not take the write");
    chk_phase_follows: assert property (wr_req && hit_out |=>
        phase_invert == $past(wdata[dmca_pkg::PHASE_INV_BIT]))
        else $error("phase invert did not take the write");

    // released mute climbs back one step per tick toward the target
    chk_mute_release: assert property (!soft_mute_r && step_tick && level_r[1] < target_r[1] |=>
        level_r[1] == $past(level_r[1]) + 8'h01)
        else $error("released mute did not step up");

    // a closed gate leaves the right target alone as well
    chk_gate_blocks_r: assert property (code_wr[1] && !load_gate_r |=> target_r[1] == $past(target_r[1]))
        else $error("closed gate let a right code through");

    cov_soft_mute_done: cover property (soft_mute_r && level_r[0] == 8'h00 && level_r[1] == 8'h00);
    cov_gated_load: cover property (code_wr[0] && load_gate_r ##1 ramp_busy);
    cov_eighth_rate: cover property (step_rate_r == 2'h3 && step_tick);
    cov_readback: cover property (rd_req && hit_fmt);
    // boundary between the last finite level and full mute
    cov_mute_edge: cover property (right_level == 8'h0f ##[1:300] right_full_mute);

endmodule : dmca_regs

// *** hw/dmca_pkg.sv ***
// Purpose: shared constants for the dac mode control and attenuation block
// Assumes: 16-bit control words, select bit on top, 7-bit address, 8-bit data
// Notes: every offset, field position, reset value and count is named here once
package dmca_pkg;

    // control word layout
    localparam int RW_BIT = 15;                 // 0 write, 1 readback
    localparam int ADDR_MSB = 14;               // address field top bit
    localparam int ADDR_LSB = 8;                // address field bottom bit
    localparam int DATA_MSB = 7;                // data field top bit

    // register offsets
    localparam logic [6:0] LEFT_ATTEN_OFS = 7'h10;   // left_attenuation_level
    localparam logic [6:0] RIGHT_ATTEN_OFS = 7'h11;  // right_attenuation_level
    localparam logic [6:0] FMT_CTRL_OFS = 7'h12;     // format_emphasis_mute_control
    localparam logic [6:0] OUT_CTRL_OFS = 7'h13;     // output_phase_rate_control

    // format_emphasis_mute_control fields
    localparam int LOAD_GATE_BIT = 7;           // atten_load_gate
    localparam int FMT_MSB = 6;                 // audio_format_sel top
    localparam int FMT_LSB = 4;                 // audio_format_sel bottom
    localparam int DEEMPH_RATE_MSB = 3;         // deemph_rate_sel top
    localparam int DEEMPH_RATE_LSB = 2;         // deemph_rate_sel bottom
    localparam int DEEMPH_EN_BIT = 1;           // deemph_enable
    localparam int SOFT_MUTE_BIT = 0;           // soft mute

    // output_phase_rate_control fields
    localparam int PHASE_INV_BIT = 7;           // phase_invert
    localparam int STEP_RATE_MSB = 6;           // atten_step_rate top
    localparam int STEP_RATE_LSB = 5;           // atten_step_rate bottom
    localparam int OUT_DIS_BIT = 4;             // output_disable

    // reset values
    localparam logic [7:0] ATTEN_RST = 8'hff;   // 0 dB
    localparam logic [2:0] FMT_RST = 3'h5;      // 24-bit i2s
    localparam logic [1:0] DEEMPH_RATE_RST = 2'h0;
    localparam logic [1:0] STEP_RATE_RST = 2'h0;
    localparam logic BIT_RST = 1'b0;            // every single-bit control

    // attenuation code figures
    localparam logic [7:0] MUTE_MAX_CODE = 8'h0e;     // 0..14 mean full mute
    localparam logic [8:0] UNITY_CODE = 9'h0ff;       // code giving 0 dB
    localparam logic [7:0] SOFT_MUTE_CODE = 8'h00;    // ramp end of soft mute
    localparam int SOFT_MUTE_STEPS = 256;             // codes the mute ramp passes from 255 to 0

    // step interval codes, in word clock periods
    typedef enum logic [1:0] {
        RATE_EVERY,
        RATE_HALF,
        RATE_QUARTER,
        RATE_EIGHTH
    } dmca_rate_t;

endpackage : dmca_pkg

// *** bench/dmca_host.sv ***
// Purpose: host controller model that issues control words to the register bank
// Assumes: one word per request, driven on the falling edge, taken on the next rising edge
// Notes: the word is scrambled once released so a stale value is never mistaken for a live one
module dmca_host (
    input wire logic clk,
    output logic ctl_valid,
    output logic [15:0] ctl_word,
    input wire logic rd_valid,
    input wire logic [7:0] rd_data
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle bus at time zero
    initial begin
        ctl_valid = 1'b0;
        ctl_word = 16'h0000;
    end

    // one request: select bit on top, then address, then data
    task automatic send(input logic rd, input logic [6:0] addr, input logic [7:0] d);
        @(negedge clk);
        ctl_word = {rd, addr, d};
        ctl_valid = 1'b1;
        @(negedge clk);
        ctl_valid = 1'b0;
        ctl_word = ~ctl_word; // released, so show garbage
    endtask : send

    // register write, select bit low
    task automatic wr(input logic [6:0] addr, input logic [7:0] d);
        send(1'b0, addr, d);
    endtask : wr

    // readback; the answer stands from the taking edge to the next one,
    // so it is picked up at the falling edge on which send returns
    task automatic rd(input logic [6:0] addr, output logic [7:0] d, output logic v);
        send(1'b1, addr, 8'h00);
        v = rd_valid;
        d = rd_data;
    endtask : rd
endmodule : dmca_host

// *** bench/tb.sv ***
// Purpose: self-checking bench for the mode control register bank
// Assumes: word clock runs free at 125 ns, unrelated in phase to clk
// Notes: random field values come from a fixed xorshift seed; ramps are waited on with bounds
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic word_clock = 1'b0;
    logic stream_mode = 1'b0;
    logic ctl_valid, rd_valid, lfm, rfm, deemph_enable, phase_invert, output_disable, bipolar_zero, ramp_busy;
    logic [15:0] ctl_word;
    logic [7:0] rd_data, left_level, right_level, d, w;
    logic signed [8:0] lg, rg;
    logic [2:0] fmt;
    logic [1:0] drate, fir;
    logic v;
    int n_fail = 0;
    int cmp_count = 0;
    logic [31:0] seed = 32'h0000_74a2; // fixed start, repeatable runs
    realtime t1, t2;

    always #5 clk = ~clk;
    // link clock, offset so its edges never line up with clk
    initial begin
        #3;
        forever #62.5 word_clock = ~word_clock;
    end

    dmca_host host (.clk(clk), .ctl_valid(ctl_valid), .ctl_word(ctl_word), .rd_valid(rd_valid), .rd_data(rd_data));
    dmca_regs dut (.clk(clk), .rst_n(rst_n), .ctl_valid(ctl_valid), .ctl_word(ctl_word), .rd_valid(rd_valid),
        .rd_data(rd_data), .word_clock(word_clock), .stream_mode(stream_mode), .left_level(left_level),
        .right_level(right_level), .left_gain_half_db(lg), .right_gain_half_db(rg), .left_full_mute(lfm),
        .right_full_mute(rfm), .audio_format_sel(fmt), .deemph_rate_sel(drate), .fir_perf_sel(fir),
        .deemph_enable(deemph_enable), .phase_invert(phase_invert), .output_disable(output_disable),
        .bipolar_zero(bipolar_zero), .ramp_busy(ramp_busy));

    // xorshift step
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    // expected gain in half dB and mute flag for a code
    function automatic logic signed [8:0] gain_of(input logic [7:0] c);
        return $signed({1'b0, c}) - 9'sh0ff;
    endfunction : gain_of
    function automatic logic mute_of(input logic [7:0] c);
        return c <= 8'h0e;
    endfunction : mute_of

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // readback with valid pulse check
    task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
        host.rd(a, d, v);
        check("rd_valid", 16'(v), 16'h0001);
        check("rd_data", 16'(d), 16'(exp));
    endtask : rd_chk

    // bounded wait for the ramp to settle
    task automatic wait_idle();
        for (int i = 0; i < 4000 && ramp_busy !== 1'b0; i++) @(negedge clk);
        check("ramp_busy", 16'(ramp_busy), 16'h0000);
    endtask : wait_idle

    // level and its decoded gain and mute
    task automatic chk_lvl(input logic [7:0] l, input logic [7:0] r);
        check("left_level", 16'(left_level), 16'(l));
        check("right_level", 16'(right_level), 16'(r));
        check("left_gain", 16'(lg), 16'(gain_of(l)));
        check("right_gain", 16'(rg), 16'(gain_of(r)));
        check("left_mute", 16'(lfm), 16'(mute_of(l)));
        check("right_mute", 16'(rfm), 16'(mute_of(r)));
    endtask : chk_lvl

    // time of the next applied left level change
    task automatic next_step(output realtime t);
        w = left_level;
        for (int i = 0; i < 2000 && left_level === w; i++) @(negedge clk);
        t = $realtime;
    endtask : next_step

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : report_and_stop

    // watchdog, several times the expected run
    initial begin
        #400us;
        n_fail++;
        report_and_stop();
    end

    initial begin
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        // reset contents
        chk_lvl(8'hff, 8'hff);
        rd_chk(dmca_pkg::LEFT_ATTEN_OFS, 8'hff);
        rd_chk(dmca_pkg::RIGHT_ATTEN_OFS, 8'hff);
        rd_chk(dmca_pkg::FMT_CTRL_OFS, 8'h50);
        rd_chk(dmca_pkg::OUT_CTRL_OFS, 8'h00);
        rd_chk(7'h14, 8'h00); // unmapped reads zero
        // random format, rate and enable fields; soft mute kept off here
        for (int i = 0; i < 12; i++) begin
            w = 8'(rnd()) & 8'h7e;
            stream_mode = 1'(rnd());
            host.wr(dmca_pkg::FMT_CTRL_OFS, w);
            rd_chk(dmca_pkg::FMT_CTRL_OFS, w);
            check("format", 16'(fmt), 16'(w[6:4]));
            check("deemph_rate", 16'(drate), stream_mode ? 16'h0000 : 16'(w[3:2]));
            check("fir_perf", 16'(fir), stream_mode ? 16'(w[3:2]) : 16'h0000);
            check("deemph_en", 16'(deemph_enable), 16'(w[1]));
            w = 8'(rnd());
            host.wr(dmca_pkg::OUT_CTRL_OFS, w);
            rd_chk(dmca_pkg::OUT_CTRL_OFS, w & 8'hf0);
            check("phase_invert", 16'(phase_invert), 16'(w[7]));
            check("bipolar_zero", 16'(bipolar_zero), 16'(w[4]));
            check("output_disable", 16'(output_disable), 16'(w[4]));
        end
        stream_mode = 1'b0;
        host.wr(dmca_pkg::OUT_CTRL_OFS, 8'h00);
        // gate closed: code stored but not applied
        host.wr(dmca_pkg::FMT_CTRL_OFS, 8'h50);
        host.wr(dmca_pkg::LEFT_ATTEN_OFS, 8'h20);
        repeat (100) @(negedge clk);
        chk_lvl(8'hff, 8'hff);
        rd_chk(dmca_pkg::LEFT_ATTEN_OFS, 8'h20);
        // gate open: walk one step at a time, right side stays
        host.wr(dmca_pkg::FMT_CTRL_OFS, 8'hd0);
        host.wr(dmca_pkg::LEFT_ATTEN_OFS, 8'hfd);
        next_step(t1);
        check("first_step", 16'(left_level), 16'h00fe);
        wait_idle();
        chk_lvl(8'hfd, 8'hff);
        // boundary codes: 15 is finite, 14 is mute
        host.wr(dmca_pkg::RIGHT_ATTEN_OFS, 8'h0f);
        wait_idle();
        chk_lvl(8'hfd, 8'h0f);
        host.wr(dmca_pkg::RIGHT_ATTEN_OFS, 8'h0e);
        wait_idle();
        chk_lvl(8'hfd, 8'h0e);
        // step interval for each rate code, 1 2 4 8 word clocks
        for (int k = 0; k < 4; k++) begin
            host.wr(dmca_pkg::OUT_CTRL_OFS, 8'(k << 5));
            host.wr(dmca_pkg::LEFT_ATTEN_OFS, (k % 2) ? 8'hfd : 8'hf9);
            next_step(t1);
            next_step(t1);
            next_step(t2);
            check("step_interval", 16'((t2 - t1) > 125.0 * (1 << k) - 20 && (t2 - t1) < 125.0 * (1 << k) + 20),
                16'h0001);
            wait_idle();
        end
        host.wr(dmca_pkg::OUT_CTRL_OFS, 8'h00);
        // soft mute both channels, then release back to the targets
        host.wr(dmca_pkg::FMT_CTRL_OFS, 8'hd1);
        wait_idle();
        chk_lvl(dmca_pkg::SOFT_MUTE_CODE, dmca_pkg::SOFT_MUTE_CODE);
        host.wr(dmca_pkg::FMT_CTRL_OFS, 8'hd0);
        wait_idle();
        chk_lvl(8'hfd, 8'h0e);
        report_and_stop();
    end
endmodule : tb
